// >>> shared/bcd_pkg.sv
// package for bridge control upper bits and discard timers
// assumes a 50 MHz clock and an AXI4-Lite register bus
package bcd_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h3C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h44;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h48;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h4C;
  localparam logic [7:0] ADDR_TMR_STAT = 8'h50;
  localparam int BIT_SEC_RESET = 22;
  localparam int BIT_FBB_EN = 23;
  localparam int BIT_PRI_SHORT = 24;
  localparam int BIT_SEC_SHORT = 25;
  localparam int BIT_TMO_STATUS = 26;
  localparam int BIT_SERR_EN = 27;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RW_MASK = 32'h0BC0_0000;
  localparam int LONG_LOG2 = 15;
  localparam int SHORT_LOG2 = 10;
  localparam int TMR_W = 16;
  localparam logic [TMR_W-1:0] LONG_CYCLES = 16'h8000;
  localparam logic [TMR_W-1:0] SHORT_CYCLES = 16'h0400;
  localparam int IRQ_PRI_EXP = 0;
  localparam int IRQ_SEC_EXP = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// >>> core/bcd_discard_timer.sv
// one discard timer: loaded when a completion is ready, stopped on repeat
// assumes start and repeat are one-cycle pulses from the transaction engine
`timescale 1ns/1ns
module bcd_discard_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic short_i,
  input wire logic start_i,
  input wire logic repeat_i,
  // state
  output logic running_o,
  output logic expire_o
);
  import bcd_pkg::*;
  typedef struct packed {
    logic running;
    logic expire;
    logic [TMR_W-1:0] count;
  } bcd_tmr_s;
  bcd_tmr_s s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.expire = 1'b0;
    if (start_i) begin
      s_d.running = 1'b1;
      s_d.count = short_i ? SHORT_CYCLES : LONG_CYCLES;
    end else if (repeat_i) begin
      s_d.running = 1'b0;
    end else if (s_q.running) begin
      if (s_q.count == 16'h0001) begin
        s_d.running = 1'b0;
        s_d.expire = 1'b1;
      end
      s_d.count = s_q.count - 16'h0001;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign running_o = s_q.running;
  assign expire_o = s_q.expire;
endmodule

// >>> core/bcd_bridge_ctrl.sv
// bridge control upper bits, two discard timers, AXI4-Lite slave
// assumes delayed-transaction engine supplies start/repeat pulses
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
// Notes on behaviour
// - control bit forces secondary bus reset
// - bit 23 gates fast back-to-back
// - primary timer 2^15 or 2^10 clocks
// - secondary timer 2^15 or 2^10 clocks
// - bit 26 sticky on expiry, write-one clears
// - bit 27 lets expiry assert system error
// - bits 31 to 28 read zero
module bcd_bridge_ctrl (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // axi4-lite write
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi4-lite read
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // delayed transaction events
  input wire logic PRI_CPL_READY_I,
  input wire logic PRI_REPEAT_I,
  input wire logic SEC_CPL_READY_I,
  input wire logic SEC_REPEAT_I,
  // bridge outputs
  output logic SEC_BUS_RESET_O,
  output logic SEC_FBB_ALLOW_O,
  output logic PRI_DISCARD_O,
  output logic SEC_DISCARD_O,
  output logic PRIMARY_SYSTEM_ERROR_OUT_O,
  output logic IRQ_O
);
  import bcd_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic irq;
    logic serr;
    logic pri_disc;
    logic sec_disc;
  } bcd_state_s;

  bcd_state_s s_q, s_d;
  logic rst_sync1_q;
  logic rst_sync2_q;
  logic pri_run;
  logic pri_exp;
  logic sec_run;
  logic sec_exp;

  // byte-lane merge of a register write
  function automatic logic [31:0] apply_strb(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  bcd_discard_timer u_pri_tmr (
    .clk_i(CLK_I),
    .rst_n_i(rst_sync2_q),
    .short_i(s_q.ctrl[BIT_PRI_SHORT]),
    .start_i(PRI_CPL_READY_I),
    .repeat_i(PRI_REPEAT_I),
    .running_o(pri_run),
    .expire_o(pri_exp)
  );

  bcd_discard_timer u_sec_tmr (
    .clk_i(CLK_I),
    .rst_n_i(rst_sync2_q),
    .short_i(s_q.ctrl[BIT_SEC_SHORT]),
    .start_i(SEC_CPL_READY_I),
    .repeat_i(SEC_REPEAT_I),
    .running_o(sec_run),
    .expire_o(sec_exp)
  );

  always_comb begin
    logic do_write;
    logic do_read;
    logic [31:0] wmask;
    logic [31:0] merged;
    do_write = 1'b0;
    do_read = 1'b0;
    wmask = '0;
    merged = '0;
    s_d = s_q;
    if (S_AXI_AWVALID_I && !s_q.aw_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && !s_q.w_got && !s_q.bvalid) begin
      s_d.w_got = 1'b1;
      s_d.w_data = S_AXI_WDATA_I;
      s_d.w_strb = S_AXI_WSTRB_I;
    end
    if (s_q.bvalid && S_AXI_BREADY_I) begin
      s_d.bvalid = 1'b0;
    end
    do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    if (do_write) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = AXI_OKAY;
      wmask = lane_mask(s_q.w_strb);
      if (s_q.aw_addr == ADDR_CTRL) begin
        merged = apply_strb(s_q.ctrl, s_q.w_data, s_q.w_strb);
        s_d.ctrl = (merged & CTRL_RW_MASK) | (s_q.ctrl & ~CTRL_RW_MASK);
        if (wmask[BIT_TMO_STATUS] && s_q.w_data[BIT_TMO_STATUS]) begin
          s_d.ctrl[BIT_TMO_STATUS] = 1'b0;
        end
      end else if (s_q.aw_addr == ADDR_IRQ_EN) begin
        if (s_q.w_strb[0]) begin
          s_d.irq_en = s_q.w_data[1:0];
        end
      end else if (s_q.aw_addr == ADDR_IRQ_CLR) begin
        if (s_q.w_strb[0]) begin
          s_d.irq_stat = s_q.irq_stat & ~s_q.w_data[1:0];
        end
      end else if (s_q.aw_addr == ADDR_IRQ_STAT || s_q.aw_addr == ADDR_TMR_STAT) begin
        s_d.bresp = AXI_OKAY;
      end else begin
        s_d.bresp = AXI_SLVERR;
      end
    end
    if (pri_exp || sec_exp) begin
      s_d.ctrl[BIT_TMO_STATUS] = 1'b1;
    end
    if (pri_exp) begin
      s_d.irq_stat[IRQ_PRI_EXP] = 1'b1;
    end
    if (sec_exp) begin
      s_d.irq_stat[IRQ_SEC_EXP] = 1'b1;
    end
    s_d.ctrl[31:28] = 4'h0;
    s_d.arready = 1'b0;
    if (s_q.rvalid && S_AXI_RREADY_I) begin
      s_d.rvalid = 1'b0;
    end
    do_read = S_AXI_ARVALID_I && !s_q.arready && !s_q.rvalid;
    if (do_read) begin
      s_d.arready = 1'b1;
      s_d.rvalid = 1'b1;
      s_d.rresp = AXI_OKAY;
      s_d.rdata = '0;
      if (S_AXI_ARADDR_I == ADDR_CTRL) begin
        s_d.rdata = s_q.ctrl;
      end else if (S_AXI_ARADDR_I == ADDR_IRQ_STAT) begin
        s_d.rdata = {30'h0, s_q.irq_stat};
      end else if (S_AXI_ARADDR_I == ADDR_IRQ_EN) begin
        s_d.rdata = {30'h0, s_q.irq_en};
      end else if (S_AXI_ARADDR_I == ADDR_IRQ_CLR) begin
        s_d.rdata = '0;
      end else if (S_AXI_ARADDR_I == ADDR_TMR_STAT) begin
        s_d.rdata = {30'h0, sec_run, pri_run};
      end else begin
        s_d.rresp = AXI_SLVERR;
      end
    end
    s_d.serr = s_q.ctrl[BIT_SERR_EN] && (pri_exp || sec_exp);
    s_d.pri_disc = pri_exp;
    s_d.sec_disc = sec_exp;
    s_d.irq = |(s_d.irq_stat & s_d.irq_en);
  end

  always_ff @(posedge CLK_I or negedge rst_sync2_q) begin
    if (!rst_sync2_q) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.irq_stat <= IRQ_RESET;
      s_q.irq_en <= IRQ_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign S_AXI_AWREADY_O = 1'b0 | (~s_q.aw_got & ~s_q.bvalid & rst_sync2_q);
  assign S_AXI_WREADY_O = ~s_q.w_got & ~s_q.bvalid & rst_sync2_q;
  assign S_AXI_BRESP_O = s_q.bresp;
  assign S_AXI_BVALID_O = s_q.bvalid;
  assign S_AXI_ARREADY_O = s_q.arready;
  assign S_AXI_RDATA_O = s_q.rdata;
  assign S_AXI_RRESP_O = s_q.rresp;
  assign S_AXI_RVALID_O = s_q.rvalid;
  assign SEC_BUS_RESET_O = s_q.ctrl[BIT_SEC_RESET];
  assign SEC_FBB_ALLOW_O = s_q.ctrl[BIT_FBB_EN];
  assign PRI_DISCARD_O = s_q.pri_disc;
  assign SEC_DISCARD_O = s_q.sec_disc;
  assign PRIMARY_SYSTEM_ERROR_OUT_O = s_q.serr;
  assign IRQ_O = s_q.irq;
endmodule

// >>> verification/bcd_initiator_model.sv
// far side initiators: completion ready and repeat pulses
// assumes tasks are called just after a rising edge
`timescale 1ns/1ns
module bcd_initiator_model (
  // clock
  input wire logic clk_i,
  // events towards the bridge
  output logic pri_cpl_o,
  output logic pri_rep_o,
  output logic sec_cpl_o,
  output logic sec_rep_o
);
  logic [3:0] ev_q = 4'h0;
  assign {sec_rep_o, sec_cpl_o, pri_rep_o, pri_cpl_o} = ev_q;
  // one-cycle pulse, index side*2+repeat
  task automatic pulse(input bit sec, input bit rep);
    ev_q <= 4'h1 << {sec, rep};
    @(posedge clk_i);
    ev_q <= 4'h0;
  endtask
endmodule

// >>> verification/bcd_bridge_ctrl_checker.sv
// port-level checks of the bridge control block
// assumes binding into bcd_bridge_ctrl by port names
`timescale 1ns/1ns
module bcd_bridge_ctrl_checker (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_ARREADY_O,
  input wire logic PRI_CPL_READY_I,
  input wire logic PRI_DISCARD_O,
  input wire logic SEC_DISCARD_O,
  input wire logic SEC_BUS_RESET_O,
  input wire logic SEC_FBB_ALLOW_O,
  input wire logic PRIMARY_SYSTEM_ERROR_OUT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence quiet_s;
    !PRI_DISCARD_O [*8];
  endsequence
  bus_reset_src_a: assert property ($changed(SEC_BUS_RESET_O) |-> $rose(S_AXI_BVALID_O))
    else $error("bus reset moved without a write");
  fbb_src_a: assert property ($changed(SEC_FBB_ALLOW_O) |-> $rose(S_AXI_BVALID_O))
    else $error("fast back-to-back moved without a write");
  pri_pulse_a: assert property (PRI_DISCARD_O |=> !PRI_DISCARD_O)
    else $error("primary discard longer than one cycle");
  sec_pulse_a: assert property (SEC_DISCARD_O |=> !SEC_DISCARD_O)
    else $error("secondary discard longer than one cycle");
  serr_cause_a: assert property (PRIMARY_SYSTEM_ERROR_OUT_O |-> PRI_DISCARD_O || SEC_DISCARD_O)
    else $error("system error without expiry");
  pri_fresh_a: assert property (PRI_CPL_READY_I |-> ##2 quiet_s)
    else $error("discard right after reload");
  aw_block_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write accepted during response");
  ar_pulse_a: assert property (S_AXI_ARREADY_O |=> !S_AXI_ARREADY_O)
    else $error("arready longer than one cycle");
endmodule
bind bcd_bridge_ctrl bcd_bridge_ctrl_checker chk (.*);

// >>> verification/test_bridge_ctrl_discard_timers.sv
// bench for bcd_bridge_ctrl: register bus, timers, system error, interrupt
// assumes the design package and the initiator model
`timescale 1ns/1ns
module test_bridge_ctrl_discard_timers;
  import bcd_pkg::*;
  logic CLK_I, RSTN_I, S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_RREADY_I;
  logic [7:0] S_AXI_AWADDR_I, S_AXI_ARADDR_I;
  logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O, rdata;
  logic [3:0] S_AXI_WSTRB_I;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, resp;
  logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  logic PRI_CPL_READY_I, PRI_REPEAT_I, SEC_CPL_READY_I, SEC_REPEAT_I;
  logic SEC_BUS_RESET_O, SEC_FBB_ALLOW_O, PRI_DISCARD_O, SEC_DISCARD_O, PRIMARY_SYSTEM_ERROR_OUT_O, IRQ_O;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  bcd_bridge_ctrl dut (.*);
  bcd_initiator_model m (.clk_i(CLK_I), .pri_cpl_o(PRI_CPL_READY_I), .pri_rep_o(PRI_REPEAT_I),
    .sec_cpl_o(SEC_CPL_READY_I), .sec_rep_o(SEC_REPEAT_I));
  initial begin
    CLK_I = 0;
    forever #10 CLK_I = ~CLK_I;
  end
  task automatic close_out();
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_BREADY_I <= 1'b1;
    do begin
      @(posedge CLK_I);
      if (S_AXI_AWREADY_O === 1'b1) S_AXI_AWVALID_I <= 1'b0;
      if (S_AXI_WREADY_O === 1'b1) S_AXI_WVALID_I <= 1'b0;
    end while (S_AXI_BVALID_O !== 1'b1);
    resp = S_AXI_BRESP_O;
  endtask
  task automatic rd(input logic [7:0] a);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_RREADY_I <= 1'b1;
    do begin
      @(posedge CLK_I);
      if (S_AXI_ARREADY_O === 1'b1) S_AXI_ARVALID_I <= 1'b0;
    end while (S_AXI_RVALID_O !== 1'b1);
    rdata = S_AXI_RDATA_O;
    resp = S_AXI_RRESP_O;
  endtask
  task automatic t_ctrl();
    rd(ADDR_CTRL);
    chk("ctrl reset", CTRL_RESET, rdata);
    chk("bus reset idle", 0, SEC_BUS_RESET_O);
    wr(ADDR_CTRL, 32'hFFFF_FFFF);
    rd(ADDR_CTRL);
    chk("ctrl all ones", CTRL_RW_MASK, rdata);
    chk("bus reset forced", 1, SEC_BUS_RESET_O);
    chk("fbb allowed", 1, SEC_FBB_ALLOW_O);
    wr(ADDR_CTRL, 32'h0000_0000);
    chk("bus reset off", 0, SEC_BUS_RESET_O);
    chk("fbb off", 0, SEC_FBB_ALLOW_O);
    rd(8'h10);
    chk("unmapped resp", AXI_SLVERR, resp);
  endtask
  task automatic t_timer(input bit sec, input bit short, input bit serr);
    logic [31:0] c;
    int n;
    c = 32'h0;
    c[sec ? BIT_SEC_SHORT : BIT_PRI_SHORT] = short;
    c[BIT_SERR_EN] = serr;
    wr(ADDR_IRQ_EN, {30'h0, serr, serr});
    wr(ADDR_CTRL, c);
    m.pulse(sec, 1'b0);
    n = 0;
    do begin
      @(posedge CLK_I);
      #1;
      n++;
    end while ((sec ? SEC_DISCARD_O : PRI_DISCARD_O) !== 1'b1 && n < 40000);
    chk("expiry cycles", (short ? (1 << SHORT_LOG2) : (1 << LONG_LOG2)) + 1, n);
    chk("system error", serr, PRIMARY_SYSTEM_ERROR_OUT_O);
    rd(ADDR_CTRL);
    chk("timeout status", c | (32'h1 << BIT_TMO_STATUS), rdata);
    rd(ADDR_IRQ_STAT);
    chk("irq status", sec ? 32'h2 : 32'h1, rdata);
    chk("irq out", serr, IRQ_O);
    wr(ADDR_CTRL, c | (32'h1 << BIT_TMO_STATUS));
    rd(ADDR_CTRL);
    chk("status cleared", c, rdata);
    wr(ADDR_IRQ_CLR, 32'h3);
    rd(ADDR_IRQ_STAT);
    chk("irq cleared", 0, rdata);
    chk("irq out low", 0, IRQ_O);
  endtask
  task automatic t_repeat();
    wr(ADDR_CTRL, 32'h1 << BIT_PRI_SHORT);
    m.pulse(1'b0, 1'b0);
    repeat (100) @(posedge CLK_I);
    m.pulse(1'b0, 1'b1);
    repeat (1100) begin
      @(posedge CLK_I);
      if (PRI_DISCARD_O !== 1'b0) chk("stopped timer", 0, PRI_DISCARD_O);
    end
    rd(ADDR_TMR_STAT);
    chk("timer idle", 0, rdata);
  endtask
  initial begin
    RSTN_I = 0;
    {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_RREADY_I} = 5'h00;
    S_AXI_AWADDR_I = 8'h00;
    S_AXI_ARADDR_I = 8'h00;
    S_AXI_WDATA_I = 32'h0;
    S_AXI_WSTRB_I = 4'hF;
    repeat (6) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    t_ctrl();
    t_timer(1'b0, 1'b1, 1'b1);
    t_timer(1'b1, 1'b1, 1'b0);
    t_repeat();
    t_timer(1'b0, 1'b0, 1'b0);
    close_out();
  end
endmodule
